// ---- design/srmf_pkg.sv ----
// Shared constants of the rectifier mode and fault supervisor
// How it works
// - Primary sense over its disable level for 500 ns kills drive until next valid cycle.
// - An open primary sense input reads as no signal, so drive stays off.
// - An open secondary sense input reads as zero, so drive stays off.
// - An open blanking program pin keeps the gate drive off.
// - Both sense inputs must pass their enable levels; a grounded input blocks drive.
// - A grounded blanking program pin selects the shortest blanking interval.
// - Below supply turn-on all is off; above it run bias starts the sequence.
// - Drive needs supply, primary over enable and dynamic levels, secondary over enable.
// - Above the standby frequency the block runs normal volt-second or dead-time control.
// - Volt-second turn-off rules while primary plus drive time fits the period limit.
// - Drive is cut at previous period minus dead-time margin when volt-second runs late.
// - Under 64 primary pulses in the entry window enters standby and stops drive.
// - Over 32 pulses in the exit window leaves standby; drive after four cycles.
// - A period above previous period times the fault factor blocks drive four cycles.
// - Another period fault during the four-cycle block restarts the block counter.
// - The dead-time margin is 600 ns.
// - The period fault factor is 150 percent.
// - Standby entry window is 12.8 ms, exit window is 2.56 ms.
// - Dynamic primary threshold is 85 percent of the previous cycle peak.
package srmf_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_NS          = 20;
  localparam int OV_TIME_NS      = 500;
  localparam int OV_CYC          = (OV_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int DT_MARGIN_NS    = 600;
  localparam int DT_MARGIN_CYC   = (DT_MARGIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLK_MIN_NS      = 200;
  localparam int BLK_MIN_CYC     = (BLK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLK_MAX_NS      = 1000;
  localparam int BLK_MAX_CYC     = BLK_MAX_NS / CLK_NS;
  localparam int ENTRY_WIN_US    = 12800;
  localparam int ENTRY_WIN_CYC   = ENTRY_WIN_US * 1000 / CLK_NS;
  localparam int EXIT_WIN_US     = 2560;
  localparam int EXIT_WIN_CYC    = EXIT_WIN_US * 1000 / CLK_NS;
  // ****************************************
  // Counts and ratios
  // ****************************************
  localparam int ENTRY_MIN_PULSES = 64;
  localparam int EXIT_MIN_PULSES  = 32;
  localparam int FAULT_CYCLES     = 4;
  localparam int RESTART_CYCLES   = 4;
  localparam int FAULT_NUM        = 3;
  localparam int FAULT_DEN        = 2;
  localparam int DYN_PCT          = 85;
  // ****************************************
  // Widths and comparator levels in sense codes
  // ****************************************
  localparam int LVL_W = 10;
  localparam int PER_W = 16;
  localparam int BLK_W = 6;
  localparam logic [LVL_W-1:0] PRI_EN_CODE = 10'h0040;
  localparam logic [LVL_W-1:0] SEC_EN_CODE = 10'h0030;
  localparam logic [LVL_W-1:0] PRI_OV_CODE = 10'h0320;
endpackage : srmf_pkg

// ---- design/srmf_pulse_window.sv ----
// Pulse counting window that decides standby entry and exit
`timescale 1ns/1ps
module srmf_pulse_window #(
  parameter int ENTRY_WIN = srmf_pkg::ENTRY_WIN_CYC,
  parameter int EXIT_WIN  = srmf_pkg::EXIT_WIN_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Supervisor side
  srmf_win_if.win   w
);
  localparam logic [7:0] ENTRY_MIN = 8'(srmf_pkg::ENTRY_MIN_PULSES);
  localparam logic [7:0] EXIT_MIN  = 8'(srmf_pkg::EXIT_MIN_PULSES);

  logic [19:0] tmr;
  logic [7:0]  cnt;
  logic        mode_q;
  logic [7:0]  next_cnt;
  logic        win_end;
  logic        restart;

  // Count including the boundary of this very cycle so none is lost
  always_comb begin
    next_cnt = (w.boundary && cnt != 8'hff) ? cnt + 8'h01 : cnt;
    win_end  = w.standby ? (tmr == 20'(EXIT_WIN - 1)) : (tmr == 20'(ENTRY_WIN - 1));
    restart  = win_end || (w.standby != mode_q) || w.exit_pulse || w.enter_pulse;
  end

  // Window timer and pulse count, restarted on each mode change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr    <= '0;
      cnt    <= '0;
      mode_q <= 1'b0;
    end else if (!w.run) begin
      tmr    <= '0;
      cnt    <= '0;
      mode_q <= 1'b0;
    end else begin
      mode_q <= w.standby;
      if (restart) begin
        tmr <= '0;
        cnt <= '0;
      end else begin
        tmr <= tmr + 20'h0_0001;
        cnt <= next_cnt;
      end
    end
  end

  // Exit fires as soon as the count passes, entry only at window end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w.enter_pulse <= 1'b0;
      w.exit_pulse  <= 1'b0;
    end else begin
      w.enter_pulse <= w.run && !w.standby && (w.standby == mode_q) && !w.enter_pulse
                       && win_end && (next_cnt < ENTRY_MIN);
      w.exit_pulse  <= w.run && w.standby && (w.standby == mode_q) && !w.exit_pulse
                       && (next_cnt > EXIT_MIN);
    end
  end

  chk_entry_decide : assert property (@(posedge clk) disable iff (!rst_b)
    (w.run && !w.standby && mode_q == 1'b0 && !w.enter_pulse && win_end && next_cnt < ENTRY_MIN)
    |=> w.enter_pulse) else $error("standby entry missed");
  chk_exit_fast : assert property (@(posedge clk) disable iff (!rst_b)
    w.exit_pulse |-> $past(w.standby) && $past(next_cnt) > EXIT_MIN)
    else $error("standby exit without enough pulses");
endmodule : srmf_pulse_window

// ---- design/srmf_top.sv ----
// Mode and fault supervisor driving the rectifier gate
`timescale 1ns/1ps
module srmf_top #(
  parameter int ENTRY_WIN = srmf_pkg::ENTRY_WIN_CYC,
  parameter int EXIT_WIN  = srmf_pkg::EXIT_WIN_CYC
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // Supply and pin fault detectors
  input  wire logic                       supply_ok,
  input  wire logic                       pri_open,
  input  wire logic                       sec_open,
  input  wire logic                       blank_open,
  input  wire logic                       blank_short,
  // Sense levels and programmed blanking
  input  wire logic [srmf_pkg::LVL_W-1:0] primary_on_sense,
  input  wire logic [srmf_pkg::LVL_W-1:0] secondary_voltsec_sense,
  input  wire logic [srmf_pkg::BLK_W-1:0] blanking_program_pin,
  input  wire logic                       voltsec_done,
  // Outputs
  output      logic                       gate_drive_output,
  output      logic                       run_bias,
  output      logic                       standby_mode
);
  localparam int LW = srmf_pkg::LVL_W;
  localparam int PW = srmf_pkg::PER_W;
  localparam int BW = srmf_pkg::BLK_W;
  localparam logic [BW-1:0] BLK_MIN = BW'(srmf_pkg::BLK_MIN_CYC);
  localparam logic [BW-1:0] BLK_MAX = BW'(srmf_pkg::BLK_MAX_CYC);
  localparam logic [PW-1:0] DT_CYC  = PW'(srmf_pkg::DT_MARGIN_CYC);
  localparam logic [4:0]    OV_N    = 5'(srmf_pkg::OV_CYC);
  localparam logic [2:0]    FLT_N   = 3'(srmf_pkg::FAULT_CYCLES);
  localparam logic [2:0]    RST_N   = 3'(srmf_pkg::RESTART_CYCLES);

  // ****************************************
  // Dynamic threshold
  // ****************************************
  function automatic logic [LW-1:0] srmf_pct(input logic [LW-1:0] peak);
    logic [LW+7:0] prod;
    prod = {8'h00, peak} * (LW+8)'(srmf_pkg::DYN_PCT);
    srmf_pct = LW'(prod / (LW+8)'(100));
  endfunction : srmf_pct

  logic [LW-1:0] pri_lv, sec_lv, peak_cur, peak_prev, dyn_th;
  logic          pri_en, pri_qual, sec_en, ov_hi;
  logic [BW-1:0] blank_cyc, hi_cnt;
  logic          boundary, armed, pri_q, have_prev, ov_trip, gate_ok, limit_hit, fault_det;
  logic [PW-1:0] per_cnt, prev_per, on_cnt, drv_cnt, limit;
  logic [4:0]    ov_cnt;
  logic [2:0]    fault_cnt, restart_cnt;
  logic          standby;

  srmf_win_if wif ();

  // Open inputs read as zero; grounded inputs then fail the enable compare
  always_comb begin
    pri_lv    = pri_open ? '0 : primary_on_sense;
    sec_lv    = sec_open ? '0 : secondary_voltsec_sense;
    dyn_th    = srmf_pct(peak_prev);
    pri_en    = pri_lv > srmf_pkg::PRI_EN_CODE;
    sec_en    = sec_lv > srmf_pkg::SEC_EN_CODE;
    pri_qual  = pri_en && (pri_lv > dyn_th);
    ov_hi     = pri_lv > srmf_pkg::PRI_OV_CODE;
    // Grounded program pin gives the floor; out of range values are clamped
    if (blank_short || blanking_program_pin < BLK_MIN) begin
      blank_cyc = BLK_MIN;
    end else if (blanking_program_pin > BLK_MAX) begin
      blank_cyc = BLK_MAX;
    end else begin
      blank_cyc = blanking_program_pin;
    end
  end

  // Peak of each primary pulse becomes the next cycle's reference
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      peak_cur  <= '0;
      peak_prev <= '0;
    end else if (!supply_ok || standby) begin
      peak_cur  <= '0;
      peak_prev <= '0;
    end else if (pri_en) begin
      peak_cur <= (pri_lv > peak_cur) ? pri_lv : peak_cur;
    end else if (peak_cur != '0) begin
      peak_prev <= peak_cur;
      peak_cur  <= '0;
    end
  end

  // ****************************************
  // Cycle boundary after blanking
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt   <= '0;
      boundary <= 1'b0;
      pri_q    <= 1'b0;
    end else begin
      pri_q    <= pri_qual;
      hi_cnt   <= (pri_qual && hi_cnt != '1) ? hi_cnt + BW'(1) : (pri_qual ? hi_cnt : '0);
      boundary <= supply_ok && pri_qual && (hi_cnt == blank_cyc - BW'(1));
    end
  end

  // Period and on-time measured from the boundary
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt   <= '0;
      prev_per  <= '0;
      on_cnt    <= '0;
      have_prev <= 1'b0;
      armed     <= 1'b0;
    end else if (!supply_ok) begin
      per_cnt   <= '0;
      prev_per  <= '0;
      on_cnt    <= '0;
      have_prev <= 1'b0;
      armed     <= 1'b0;
    end else if (boundary) begin
      if (per_cnt != '0) begin
        prev_per  <= per_cnt;
        have_prev <= 1'b1;
      end
      per_cnt <= PW'(1);
      on_cnt  <= PW'(blank_cyc) + PW'(1);
      armed   <= 1'b1;
    end else begin
      per_cnt <= (per_cnt != '0 && per_cnt != '1) ? per_cnt + PW'(1) : per_cnt;
      if (pri_q && on_cnt != '1) begin
        on_cnt <= on_cnt + PW'(1);
      end
      if (armed && !pri_qual && pri_q) begin
        armed <= 1'b0;
      end
    end
  end

  // ****************************************
  // Faults
  // ****************************************
  // Overvoltage held past 500 ns blocks drive; cleared by the next valid boundary
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ov_cnt  <= '0;
      ov_trip <= 1'b0;
    end else begin
      ov_cnt <= ov_hi ? ((ov_cnt != OV_N) ? ov_cnt + 5'h01 : ov_cnt) : '0;
      if (ov_hi && ov_cnt == OV_N - 5'h01) begin
        ov_trip <= 1'b1;
      end else if (boundary && !ov_hi) begin
        ov_trip <= 1'b0;
      end
    end
  end

  // Period growth over 150 percent of the previous one, integer compare
  always_comb begin
    fault_det = have_prev && ({2'b00, per_cnt} * (PW+2)'(srmf_pkg::FAULT_DEN)
                > {2'b00, prev_per} * (PW+2)'(srmf_pkg::FAULT_NUM));
  end

  // Four-cycle block, reloaded by any fault inside it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_cnt <= '0;
    end else if (!supply_ok) begin
      fault_cnt <= '0;
    end else if (boundary && fault_det) begin
      fault_cnt <= FLT_N;
    end else if (boundary && fault_cnt != '0) begin
      fault_cnt <= fault_cnt - 3'h1;
    end
  end

  // ****************************************
  // Standby and start-up
  // ****************************************
  assign wif.run      = supply_ok;
  assign wif.boundary = boundary;
  assign wif.standby  = standby;

  srmf_pulse_window #(
    .ENTRY_WIN(ENTRY_WIN),
    .EXIT_WIN (EXIT_WIN)
  ) u_win (
    .clk  (clk),
    .rst_b(rst_b),
    .w    (wif)
  );

  // Standby flag and the four-cycle delay after leaving it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      standby     <= 1'b0;
      restart_cnt <= '0;
    end else if (!supply_ok) begin
      standby     <= 1'b0;
      restart_cnt <= '0;
    end else if (wif.enter_pulse) begin
      standby <= 1'b1;
    end else if (wif.exit_pulse) begin
      standby     <= 1'b0;
      restart_cnt <= RST_N;
    end else if (boundary && restart_cnt != '0) begin
      restart_cnt <= restart_cnt - 3'h1;
    end
  end

  // ****************************************
  // Gate drive
  // ****************************************
  // Limit stays zero when the period is shorter than the margin, so no drive
  always_comb begin
    limit     = (prev_per > DT_CYC) ? prev_per - DT_CYC : '0;
    limit_hit = ({1'b0, on_cnt} + {1'b0, drv_cnt} + (PW+1)'(1)) >= {1'b0, limit};
    gate_ok   = supply_ok && !standby && !blank_open && !pri_open && !sec_open && sec_en
                && have_prev && fault_cnt == '0 && restart_cnt == '0 && !ov_trip;
  end

  // Drive opens after a qualified primary pulse, closes on volt-second or limit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_drive_output <= 1'b0;
      drv_cnt           <= '0;
    end else if (!gate_ok || pri_en) begin
      gate_drive_output <= 1'b0;
      drv_cnt           <= '0;
    end else if (gate_drive_output) begin
      gate_drive_output <= !voltsec_done && !limit_hit;
      drv_cnt           <= drv_cnt + PW'(1);
    end else if (armed && pri_q && !pri_qual && !limit_hit) begin
      gate_drive_output <= 1'b1;
      drv_cnt           <= '0;
    end
  end

  // Status outputs, registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_bias     <= 1'b0;
      standby_mode <= 1'b0;
    end else begin
      run_bias     <= supply_ok && !standby;
      standby_mode <= standby;
    end
  end

  chk_ov_block : assert property (@(posedge clk) disable iff (!rst_b)
    ov_trip |=> !gate_drive_output) else $error("drive during overvoltage");
  chk_open_pins : assert property (@(posedge clk) disable iff (!rst_b)
    (pri_open || sec_open || blank_open) |=> !gate_drive_output) else $error("drive with open pin");
  chk_blank_floor : assert property (@(posedge clk) disable iff (!rst_b)
    (blank_short && pri_qual && hi_cnt == BLK_MIN - BW'(1) && supply_ok) |=> boundary)
    else $error("short pin blanking not minimal");
  chk_supply_off : assert property (@(posedge clk) disable iff (!rst_b)
    !supply_ok |=> !gate_drive_output && !run_bias) else $error("active below turn-on");
  chk_drive_start : assert property (@(posedge clk) disable iff (!rst_b)
    $rose(gate_drive_output) |-> $past(armed && sec_en && !pri_en && !standby && fault_cnt == '0))
    else $error("drive started without enables");
  chk_dt_limit : assert property (@(posedge clk) disable iff (!rst_b)
    gate_drive_output |-> ({1'b0, on_cnt} + {1'b0, drv_cnt}) < {1'b0, limit})
    else $error("drive beyond dead-time limit");
  chk_voltsec_off : assert property (@(posedge clk) disable iff (!rst_b)
    (gate_drive_output && voltsec_done) |=> !gate_drive_output) else $error("volt-second end ignored");
  chk_fault_load : assert property (@(posedge clk) disable iff (!rst_b)
    (supply_ok && boundary && fault_det) |=> fault_cnt == FLT_N) else $error("fault block not loaded");
  chk_restart_wait : assert property (@(posedge clk) disable iff (!rst_b)
    (supply_ok && wif.exit_pulse) |=> restart_cnt == RST_N && !standby) else $error("exit delay not set");
endmodule : srmf_top

// ---- design/srmf_win_if.sv ----
// Carrier between the supervisor and its pulse window counter
`timescale 1ns/1ps
interface srmf_win_if;
  logic run;
  logic boundary;
  logic standby;
  logic enter_pulse;
  logic exit_pulse;
  modport ctrl (output run, output boundary, output standby, input enter_pulse, input exit_pulse);
  modport win  (input run, input boundary, input standby, output enter_pulse, output exit_pulse);
endinterface : srmf_win_if

// ---- testbench/srmf_sense_model.sv ----
// Behavioural model of the secondary sense network and the rectifier ramp
`timescale 1ns/1ps
module srmf_sense_model (
  // Clock and gate feedback
  input  wire logic       clk,
  input  wire logic       gate_drive_output,
  // Sense outputs
  output      logic [9:0] primary_on_sense,
  output      logic [9:0] secondary_voltsec_sense,
  output      logic       voltsec_done
);
  // ****************************************
  // Knobs and observations
  // ****************************************
  logic [9:0] sec_lvl;
  int         vs_delay;
  int         rises;
  int         wmax;
  int         gcnt;
  // Divider resistor to ground idles the primary sense line at zero; the secondary level starts at 10'h0100
  initial begin
    primary_on_sense = 10'h0000;
    sec_lvl = 10'h0100;
    vs_delay = 0;
    gcnt = 0;
    voltsec_done = 1'b0;
  end
  assign secondary_voltsec_sense = sec_lvl;
  // Ramp crosses after vs_delay drive cycles; zero models a ramp that never ends
  always @(negedge clk) begin
    gcnt = (gate_drive_output === 1'b1) ? gcnt + 1 : 0;
    voltsec_done <= (vs_delay > 0) && (gcnt >= vs_delay);
  end
  // One primary pulse, counting gate pulses and the widest one
  task automatic pulse(input int on, input int per, input logic [9:0] amp);
    int i;
    int w;
    rises = 0;
    wmax = 0;
    w = 0;
    for (i = 0; i < per; i++) begin
      @(negedge clk);
      primary_on_sense <= (i < on) ? amp : 10'h0000;
      if (gate_drive_output === 1'b1) begin
        if (w == 0) rises++;
        w++;
        if (w > wmax) wmax = w;
      end else w = 0;
    end
  endtask : pulse
endmodule : srmf_sense_model

// ---- testbench/srmf_top_tb_top.sv ----
// Self-checking bench of the rectifier mode and fault supervisor
`timescale 1ns/1ps
module srmf_top_tb_top;
  // ****************************************
  // Signals and bench state
  // ****************************************
  logic        clk, rst_b, supply_ok, pri_open, sec_open, blank_open, blank_short;
  logic        voltsec_done, gate_drive_output, run_bias, standby_mode;
  logic [9:0]  pri, sec;
  logic [5:0]  blk;
  logic [31:0] seed;
  int          n_errors, compares, nb, last, fault, pp, i, k, bprev;
  srmf_top #(.ENTRY_WIN(10000), .EXIT_WIN(400)) dut (
    .clk(clk), .rst_b(rst_b), .supply_ok(supply_ok), .pri_open(pri_open), .sec_open(sec_open),
    .blank_open(blank_open), .blank_short(blank_short), .primary_on_sense(pri),
    .secondary_voltsec_sense(sec), .blanking_program_pin(blk), .voltsec_done(voltsec_done),
    .gate_drive_output(gate_drive_output), .run_bias(run_bias), .standby_mode(standby_mode));
  srmf_sense_model sense (.clk(clk), .gate_drive_output(gate_drive_output), .primary_on_sense(pri),
    .secondary_voltsec_sense(sec), .voltsec_done(voltsec_done));
  // Free-running 50 MHz clock
  always #10 clk = ~clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // ****************************************
  // Reference model: drive expected per pulse from the period history
  // ****************************************
  function automatic int model(input int per, input bit ov, input bit en);
    if (nb >= 2 && per * 2 > last * 3) fault = 4;
    else if (fault > 0) fault--;
    if (nb >= 1) last = per;
    nb++;
    return (en && !ov && fault == 0 && nb >= 2) ? 1 : 0;
  endfunction : model
  task automatic chk(input int got, input int exp, input string what);
    compares++;
    if (got != exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk_bit
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  // Pulses of 25 on cycles; vsd below zero picks a random ramp delay, zero never ends it
  task automatic burst(input int n, input int per, input bit cmp, input bit en, input int vsd);
    int j, e, hi;
    for (j = 0; j < n; j++) begin
      e = model(pp, 1'b0, en);
      blk = 6'(10 + xs() % 8);
      sense.vs_delay = (vsd < 0) ? 5 + int'(xs() % 20) : vsd;
      // Period runs between blanked boundaries, so it shifts with the blanking change
      hi = (vsd == 0) ? pp + int'(blk) - bprev - 55 : sense.vs_delay + 2;
      sense.pulse(25, per, 10'h0300);
      pp = per;
      bprev = int'(blk);
      if (cmp) chk(sense.rises, e, "drive count");
      if (cmp && e == 1) chk(int'(sense.wmax <= hi && sense.wmax >= hi - 6), 1, "drive width");
    end
  endtask : burst
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 0;
    rst_b = 0;
    {supply_ok, pri_open, sec_open, blank_open, blank_short} = 5'b0_0000;
    blk = 6'h14;
    seed = 32'h10d5;
    bprev = int'(blk);
    {n_errors, compares, nb, last, fault, pp} = 0;
    repeat (16) @(negedge clk);
    rst_b = 1;
    supply_ok = 1;
    burst(4, 100, 0, 1, -1);
    chk_bit(run_bias, 1'b1, "run bias after start");
    burst(12, 100, 1, 1, -1);
    burst(6, 100, 1, 1, 0);
    $display("test normal and limit done");
    // Open pins, grounded senses and supply loss each keep drive off
    for (i = 0; i < 6; i++) begin
      pri_open = (i == 0);
      sec_open = (i == 1);
      blank_open = (i == 2);
      sense.sec_lvl = (i == 3) ? 10'h0000 : 10'h0100;
      supply_ok = (i != 4);
      for (k = 0; k < 6; k++) begin
        sense.pulse(25, 100, (i == 5) ? 10'h0000 : 10'h0300);
        chk(sense.rises, 0, "drive while blocked");
      end
      if (i == 4) chk_bit(run_bias, 1'b0, "run bias with supply low");
      {pri_open, sec_open, blank_open, supply_ok} = 4'b0001;
      sense.sec_lvl = 10'h0100;
      nb = 0;
      fault = 0;
      burst(7, 100, 0, 1, -1);
      burst(1, 100, 1, 1, -1);
    end
    $display("test pin faults done");
    // Overvoltage pulse drops drive for its own cycle only
    chk(model(pp, 1'b1, 1'b1), 0, "model overvoltage");
    sense.pulse(30, 100, 10'h0330);
    chk(sense.rises, 0, "drive after overvoltage");
    burst(3, 100, 1, 1, -1);
    $display("test overvoltage done");
    // Ringing under the dynamic threshold is no cycle; the merged period then faults
    sense.pulse(25, 100, 10'h0200);
    chk(sense.rises, 0, "drive on ringing");
    pp = pp + 100;
    // Long periods trip and retrigger the four-cycle disable
    burst(1, 200, 1, 1, -1);
    burst(2, 100, 1, 1, -1);
    burst(1, 400, 1, 1, -1);
    burst(8, 100, 1, 1, -1);
    $display("test period fault done");
    // Silence until standby, then a fast burst with the blanking pin grounded
    k = 0;
    while (standby_mode !== 1'b1 && k < 30000) begin
      @(negedge clk);
      k++;
    end
    chk_bit(standby_mode, 1'b1, "standby entry");
    if (k >= 30000) close_out();
    @(negedge clk);
    chk_bit(run_bias, 1'b0, "run bias in standby");
    blank_short = 1;
    blk = 6'h3f;
    sense.vs_delay = 5;
    for (k = 0; k < 75; k++) sense.pulse(11, 12, 10'h0300);
    chk_bit(standby_mode, 1'b0, "standby exit");
    blank_short = 0;
    nb = 0;
    fault = 0;
    burst(7, 100, 0, 1, -1);
    burst(3, 100, 1, 1, -1);
    $display("test standby done");
    close_out();
  end
  // Watchdog against a stalled sequence
  initial begin
    #1800000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : srmf_top_tb_top
